// ### verilog/pot_regs_pkg.sv
package pot_regs_pkg;
   localparam int DATA_W = 9;
   localparam int ADDR_W = 4;
   localparam int POTS = 2;
   localparam int TERM_BITS = 4;

   localparam logic [3:0] A_VWIPER0 = 4'h0;
   localparam logic [3:0] A_VWIPER1 = 4'h1;
   localparam logic [3:0] A_NVWIPER0 = 4'h2;
   localparam logic [3:0] A_NVWIPER1 = 4'h3;
   localparam logic [3:0] A_TERMINAL_CONNECT_CTRL = 4'h4;
   localparam logic [3:0] A_STATUS = 4'h5;
   localparam logic [3:0] A_GP_FIRST = 4'h6;

   localparam int ST_WP_BIT = 0;
   localparam int ST_LOCK0_BIT = 1;
   localparam int ST_NVWIP_BIT = 3;
   localparam int ST_RSVD_LSB = 4;
   localparam logic [4:0] ST_RSVD_ONES = 5'h1f;

   localparam int TERMINAL_CONNECT_CTRL_GC_BIT = 8;
   localparam logic [8:0] TERMINAL_CONNECT_CTRL_RESET = 9'h1ff;

   typedef enum logic [1:0] {CMD_WRITE, CMD_READ, CMD_INC, CMD_DEC} cmd_e;

   typedef struct packed {
      logic valid;
      cmd_e op;
      logic [3:0] addr;
      logic [8:0] data;
   } cmd_s;

   typedef struct packed {
      logic valid;
      logic refused;
      logic hit;
      logic [8:0] data;
   } resp_s;

   typedef struct packed {
      logic [1:0] lock;
      logic wp;
   } nv_cfg_s;

   typedef struct packed {
      logic [1:0] we;
      cmd_e op;
      logic [8:0] data;
   } wiper_s;

   typedef struct packed {
      logic we;
      logic [3:0] addr;
      logic [8:0] data;
   } nv_wr_s;
endpackage

// ### verilog/volatile_status_terminal_regs.sv
`timescale 1ns/1ps
// Functional notes
// [RQ1] status word sits at address 05h, readable, never written directly
// [RQ2] status bits 8 to 4 always read as ones
// [RQ3] status bit 3 shows non-volatile write in progress, zero after reset
// [RQ4] while writing non-volatile, only addresses 00h 01h 04h 05h are served
// [RQ5] network-1 lock blocks its wipers and its four terminal bits only
// [RQ6] network-0 lock blocks its wipers and its four terminal bits
// [RQ7] lock bits follow last lock programming and reload after reset
// [RQ8] ordinary writes never change lock or protect bits; only high-voltage programming
// [RQ9] status bit 0 is protect pin OR internal protect bit
// [RQ10] protection refuses every non-volatile write, wipers and general purpose
// [RQ11] protection never blocks volatile wiper or terminal word changes
// [RQ12] eight terminal connect controls, four per network, each separate
// [RQ13] new terminal word reaches the terminals only after its command completes
// [RQ14] terminal word resets to 1FFh, all terminals connected
// [RQ15] host rewrites the terminal word after it detects a reset
// [RQ16] one terminal word bit enables general call acceptance
// [RQ17] terminal changes leave stored wiper values untouched
// [RQ18] bit 8 general call, bits 7-4 network 1, bits 3-0 network 0
// [RQ19] writes to locked or protected locations complete quietly with no change
module volatile_status_terminal_regs #(
   parameter int DATA_W = pot_regs_pkg::DATA_W
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire pot_regs_pkg::cmd_s cmd,
   input wire logic cmd_done,
   input wire logic wp_pin_n,
   input wire logic nv_busy,
   input wire pot_regs_pkg::nv_cfg_s nv_cfg,
   input wire logic nv_cfg_done,
   output pot_regs_pkg::resp_s resp,
   output pot_regs_pkg::wiper_s wiper_cmd,
   output pot_regs_pkg::nv_wr_s nv_wr,
   output logic [7:0] terminal_connect,
   output logic general_call_accept_en
);

   typedef struct packed {
      pot_regs_pkg::resp_s resp;
      pot_regs_pkg::wiper_s wiper;
      pot_regs_pkg::nv_wr_s nv;
      logic [8:0] terminal_connect_ctrl;
      logic [8:0] applied;
      logic [1:0] lock;
      logic nv_wp;
      logic busy;
      logic wp_s1;
      logic wp_s2;
      logic loaded;
   } state_s;

   state_s r;
   state_s n;

   generate
      if (DATA_W != pot_regs_pkg::DATA_W) begin : g_bad_width
         $error("register width must be 9");
      end
   endgenerate

   logic protect;
   logic [8:0] status;

   // protect pin is active low; the pin only enters through the second flop
   assign protect = ~r.wp_s2 | r.nv_wp; // [RQ9]

   always_comb begin
      status = '0;
      status[8:pot_regs_pkg::ST_RSVD_LSB] = pot_regs_pkg::ST_RSVD_ONES; // [RQ2]
      status[pot_regs_pkg::ST_NVWIP_BIT] = r.busy; // [RQ3]
      status[pot_regs_pkg::ST_LOCK0_BIT +: 2] = r.lock; // [RQ7]
      status[pot_regs_pkg::ST_WP_BIT] = protect; // [RQ9]
   end

   always_comb begin
      logic vol;
      logic [0:0] pot;
      vol = 1'b0;
      pot = 1'b0;
      n = r;
      n.resp = '0;
      n.wiper.we = 2'b00;
      n.nv.we = 1'b0;
      n.wp_s1 = wp_pin_n;
      n.wp_s2 = r.wp_s1;
      n.busy = nv_busy; // [RQ3]

      // locks and protect change only by reload or high-voltage result
      if (!r.loaded || nv_cfg_done) begin
         n.loaded = 1'b1;
         n.lock = nv_cfg.lock; // [RQ7] [RQ8]
         n.nv_wp = nv_cfg.wp; // [RQ8]
      end

      // terminals see the new word only at command end
      if (cmd_done) begin
         n.applied = r.terminal_connect_ctrl; // [RQ13]
      end

      if (cmd.valid) begin
         vol = (cmd.addr == pot_regs_pkg::A_VWIPER0) || (cmd.addr == pot_regs_pkg::A_VWIPER1) ||
               (cmd.addr == pot_regs_pkg::A_TERMINAL_CONNECT_CTRL) || (cmd.addr == pot_regs_pkg::A_STATUS);
         pot = cmd.addr[0:0];
         n.resp.valid = 1'b1;
         if (r.busy && !vol) begin
            n.resp.refused = 1'b1; // [RQ4]
         end else begin
            unique case (cmd.op)
               pot_regs_pkg::CMD_READ: begin
                  if (cmd.addr == pot_regs_pkg::A_STATUS) begin
                     n.resp.hit = 1'b1;
                     n.resp.data = status; // [RQ1]
                  end else if (cmd.addr == pot_regs_pkg::A_TERMINAL_CONNECT_CTRL) begin
                     n.resp.hit = 1'b1;
                     n.resp.data = r.terminal_connect_ctrl;
                  end
               end
               pot_regs_pkg::CMD_WRITE: begin
                  if (cmd.addr == pot_regs_pkg::A_VWIPER0 ||
                      cmd.addr == pot_regs_pkg::A_VWIPER1) begin
                     // lock gates, protect does not
                     if (!r.lock[pot]) begin // [RQ5] [RQ6] [RQ11] [RQ19]
                        n.wiper.we[pot] = 1'b1;
                        n.wiper.op = cmd.op;
                        n.wiper.data = cmd.data;
                     end
                  end else if (cmd.addr == pot_regs_pkg::A_NVWIPER0 ||
                               cmd.addr == pot_regs_pkg::A_NVWIPER1) begin
                     if (!r.lock[pot] && !protect) begin // [RQ5] [RQ6] [RQ10] [RQ19]
                        n.nv.we = 1'b1;
                        n.nv.addr = cmd.addr;
                        n.nv.data = cmd.data;
                     end
                  end else if (cmd.addr == pot_regs_pkg::A_TERMINAL_CONNECT_CTRL) begin
                     // per network nibble, wiper values are not touched
                     for (int p = 0; p < pot_regs_pkg::POTS; p++) begin
                        if (!r.lock[p]) begin // [RQ5] [RQ6] [RQ11] [RQ12] [RQ17]
                           n.terminal_connect_ctrl[p*pot_regs_pkg::TERM_BITS +: pot_regs_pkg::TERM_BITS] =
                              cmd.data[p*pot_regs_pkg::TERM_BITS +: pot_regs_pkg::TERM_BITS];
                        end
                     end
                     n.terminal_connect_ctrl[pot_regs_pkg::TERMINAL_CONNECT_CTRL_GC_BIT] = cmd.data[pot_regs_pkg::TERMINAL_CONNECT_CTRL_GC_BIT]; // [RQ16]
                  end else if (cmd.addr >= pot_regs_pkg::A_GP_FIRST) begin
                     if (!protect) begin // [RQ10] [RQ19]
                        n.nv.we = 1'b1;
                        n.nv.addr = cmd.addr;
                        n.nv.data = cmd.data;
                     end
                  end
                  // status writes fall through with no effect [RQ1] [RQ8]
               end
               pot_regs_pkg::CMD_INC, pot_regs_pkg::CMD_DEC: begin
                  if ((cmd.addr == pot_regs_pkg::A_VWIPER0 ||
                       cmd.addr == pot_regs_pkg::A_VWIPER1) && !r.lock[pot]) begin // [RQ5] [RQ6] [RQ11]
                     n.wiper.we[pot] = 1'b1;
                     n.wiper.op = cmd.op;
                     n.wiper.data = '0;
                  end
               end
            endcase
         end
      end
   end

   // locks and protect start set so nothing slips past before the reload
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r.resp <= '0;
         r.wiper <= '0;
         r.nv <= '0;
         r.terminal_connect_ctrl <= pot_regs_pkg::TERMINAL_CONNECT_CTRL_RESET; // [RQ14]
         r.applied <= pot_regs_pkg::TERMINAL_CONNECT_CTRL_RESET; // [RQ14]
         r.lock <= 2'b11;
         r.nv_wp <= 1'b1;
         r.busy <= 1'b0; // [RQ3]
         r.wp_s1 <= 1'b0;
         r.wp_s2 <= 1'b0;
         r.loaded <= 1'b0;
      end else begin
         r <= n;
      end
   end

   assign resp = r.resp;
   assign wiper_cmd = r.wiper;
   assign nv_wr = r.nv;
   assign terminal_connect = r.applied[7:0]; // [RQ18]
   assign general_call_accept_en = r.applied[pot_regs_pkg::TERMINAL_CONNECT_CTRL_GC_BIT]; // [RQ16] [RQ18]

endmodule

// ### sim/nv_store_model.sv
`timescale 1ns/1ps
module nv_store_model #(
   parameter int BUSY_CYC = 12
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire pot_regs_pkg::nv_wr_s nv_wr,
   input wire logic hv_go,
   input wire pot_regs_pkg::nv_cfg_s hv_cfg,
   output logic nv_busy,
   output pot_regs_pkg::nv_cfg_s nv_cfg,
   output logic nv_cfg_done
);
   // cells are non-volatile, so they survive reset
   pot_regs_pkg::nv_cfg_s cfg_r = '0;
   logic done_r = 1'b0;
   int left = 0;
   assign nv_busy = left != 0;
   assign nv_cfg = cfg_r;
   assign nv_cfg_done = done_r;
   always @(posedge clk) begin
      done_r <= hv_go;
      if (hv_go) cfg_r <= hv_cfg;
      // brown-out aborts a cycle in progress
      if (!reset_n) left <= 0;
      else if (nv_wr.we) left <= BUSY_CYC;
      else if (left != 0) left <= left - 1;
   end
endmodule

// ### sim/pot_regs_monitor.sv
`timescale 1ns/1ps
module pot_regs_monitor (
   input wire logic clk,
   input wire logic reset_n,
   input wire pot_regs_pkg::cmd_s cmd,
   input wire logic cmd_done,
   input wire logic wp_pin_n,
   input wire logic nv_busy,
   input wire pot_regs_pkg::nv_cfg_s nv_cfg,
   input wire logic nv_cfg_done,
   input wire pot_regs_pkg::resp_s resp,
   input wire pot_regs_pkg::wiper_s wiper_cmd,
   input wire pot_regs_pkg::nv_wr_s nv_wr,
   input wire logic [7:0] terminal_connect,
   input wire logic general_call_accept_en
);
   logic rd_st;
   logic wr;
   assign rd_st = cmd.valid && cmd.op == pot_regs_pkg::CMD_READ && cmd.addr == 4'h5;
   assign wr = cmd.valid && cmd.op == pot_regs_pkg::CMD_WRITE;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_rsvd; rd_st |=> resp.hit && !resp.refused && resp.data[8:4] == 5'h1f; endproperty
   a_rsvd: assert property (p_rsvd) else $error("status reserved bits wrong");
   property p_refuse; cmd.valid && cmd.addr > 4'h5 && nv_busy && $past(nv_busy) |=> resp.refused && !nv_wr.we; endproperty
   a_refuse: assert property (p_refuse) else $error("busy command not refused");
   property p_vol; cmd.valid && cmd.addr inside {4'h0, 4'h1, 4'h4, 4'h5} |=> resp.valid && !resp.refused; endproperty
   a_vol: assert property (p_vol) else $error("volatile command refused");
   property p_lock1; wr && cmd.addr == 4'h1 && nv_cfg.lock[1] && $past(nv_cfg.lock[1]) |=> resp.valid && !resp.refused && wiper_cmd.we == 2'b00; endproperty
   a_lock1: assert property (p_lock1) else $error("locked wiper written");
   property p_free0; wr && cmd.addr == 4'h0 && !nv_cfg.lock[0] && !$past(nv_cfg.lock[0]) |=> wiper_cmd.we == 2'b01 && wiper_cmd.data == $past(cmd.data); endproperty
   a_free0: assert property (p_free0) else $error("free wiper not written");
   property p_wp; (!wp_pin_n)[*3] ##0 wr |=> !nv_wr.we; endproperty
   a_wp: assert property (p_wp) else $error("protected write passed");
   property p_term; $changed({general_call_accept_en, terminal_connect}) |-> $past(cmd_done); endproperty
   a_term: assert property (p_term) else $error("terminals changed without completion");
   property p_lock_st; rd_st && $stable(nv_cfg) |=> resp.data[2:1] == $past(nv_cfg.lock); endproperty
   a_lock_st: assert property (p_lock_st) else $error("lock status wrong");
endmodule

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   pot_regs_pkg::cmd_s cmd = '0;
   logic cmd_done = 1'b0;
   logic wp_pin_n = 1'b1;
   logic hv_go = 1'b0;
   pot_regs_pkg::nv_cfg_s hv_cfg = '0;
   logic nv_busy;
   logic nv_cfg_done;
   pot_regs_pkg::nv_cfg_s nv_cfg;
   pot_regs_pkg::resp_s resp;
   pot_regs_pkg::wiper_s wiper_cmd;
   pot_regs_pkg::nv_wr_s nv_wr;
   logic [7:0] terminal_connect;
   logic general_call_accept_en;
   int failures = 0;
   int num_checks = 0;
   logic [8:0] terminal_connect_ctrl = 9'h1ff;
   logic [8:0] app;
   logic [8:0] d;
   logic a;
   pot_regs_pkg::resp_s r;
   pot_regs_pkg::nv_cfg_s c;
   always #2.5 clk = ~clk;
   volatile_status_terminal_regs volatile_status_terminal_regs_inst (.clk, .reset_n, .cmd,
      .cmd_done, .wp_pin_n, .nv_busy, .nv_cfg, .nv_cfg_done, .resp, .wiper_cmd, .nv_wr,
      .terminal_connect, .general_call_accept_en);
   nv_store_model nv_store_model_inst (.clk, .reset_n, .nv_wr, .hv_go, .hv_cfg, .nv_busy,
      .nv_cfg, .nv_cfg_done);
   task automatic chk(string what, logic [8:0] exp, logic [8:0] got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic op(pot_regs_pkg::cmd_e o, logic [3:0] ad, logic [8:0] v);
      @(posedge clk) cmd <= '{1'b1, o, ad, v};
      @(posedge clk) cmd <= '0;
      #1 r = resp;
   endtask
   task automatic pulse_done();
      @(posedge clk) cmd_done <= 1'b1;
      @(posedge clk) cmd_done <= 1'b0;
      #1;
   endtask
   task automatic prog(pot_regs_pkg::nv_cfg_s v);
      @(posedge clk) begin
         hv_go <= 1'b1;
         hv_cfg <= v;
      end
      @(posedge clk) hv_go <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   function automatic logic [8:0] merge(logic [8:0] o, logic [8:0] n, logic [1:0] lk);
      return {n[8], lk[1] ? o[7:4] : n[7:4], lk[0] ? o[3:0] : n[3:0]};
   endfunction
   function automatic logic [8:0] status(logic busy, pot_regs_pkg::nv_cfg_s v, logic pin_n);
      return {5'h1f, busy, v.lock, v.wp | ~pin_n};
   endfunction
   task automatic complete_run();
      if (failures == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      failures++;
      complete_run();
   end
   initial begin
      void'($urandom(66603));
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk("terminals", 9'h1ff, {general_call_accept_en, terminal_connect});
      for (int i = 0; i < 24; i++) begin
         // first two passes: all locked, then all free with everything cut
         c = (i == 0) ? 3'b110 : (i == 1) ? 3'b000 : 3'($urandom_range(7));
         d = (i < 2) ? 9'h000 : 9'($urandom);
         wp_pin_n <= 1'($urandom);
         prog(c);
         app = terminal_connect_ctrl;
         op(pot_regs_pkg::CMD_WRITE, pot_regs_pkg::A_TERMINAL_CONNECT_CTRL, d);
         chk("refused", 9'h0, r.refused);
         terminal_connect_ctrl = merge(terminal_connect_ctrl, d, c.lock);
         op(pot_regs_pkg::CMD_READ, pot_regs_pkg::A_TERMINAL_CONNECT_CTRL, 9'h0);
         chk("terminal_connect_ctrl", terminal_connect_ctrl, r.data);
         chk("early", app, {general_call_accept_en, terminal_connect});
         pulse_done();
         chk("applied", terminal_connect_ctrl, {general_call_accept_en, terminal_connect});
         op(pot_regs_pkg::CMD_WRITE, pot_regs_pkg::A_STATUS, 9'h0);
         op(pot_regs_pkg::CMD_READ, pot_regs_pkg::A_STATUS, 9'h0);
         chk("status", status(1'b0, c, wp_pin_n), r.data);
         a = 1'($urandom);
         op(pot_regs_pkg::CMD_WRITE, {3'h0, a}, d);
         chk("wiper", c.lock[a] ? 9'h0 : 9'(2'b01 << a), wiper_cmd.we);
      end
      wp_pin_n <= 1'b1;
      prog(3'b010);
      op(pot_regs_pkg::CMD_WRITE, 4'h6, 9'h0a5);
      chk("nv_we", 9'h1, nv_wr.we);
      chk("nv_addr", 9'h6, nv_wr.addr);
      chk("nv_data", 9'h0a5, nv_wr.data);
      // busy reaches the status bit one edge after the store raises it
      @(posedge clk);
      op(pot_regs_pkg::CMD_WRITE, 4'h7, 9'h0);
      chk("busy_ref", 9'h1, r.refused);
      op(pot_regs_pkg::CMD_READ, pot_regs_pkg::A_STATUS, 9'h0);
      chk("busy_st", status(1'b1, 3'b010, 1'b1), r.data);
      repeat (20) @(posedge clk);
      wp_pin_n <= 1'b0;
      repeat (3) @(posedge clk);
      op(pot_regs_pkg::CMD_WRITE, 4'h3, 9'h011);
      chk("wp_we", 9'h0, nv_wr.we);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("rst_term", 9'h1ff, {general_call_accept_en, terminal_connect});
      @(posedge clk) reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      op(pot_regs_pkg::CMD_READ, pot_regs_pkg::A_STATUS, 9'h0);
      chk("rst_st", status(1'b0, 3'b010, 1'b0), r.data);
      chk("rst_hit", 9'h1, r.hit);
      op(pot_regs_pkg::CMD_WRITE, pot_regs_pkg::A_TERMINAL_CONNECT_CTRL, 9'h000);
      pulse_done();
      chk("rewrite", 9'h00f, {general_call_accept_en, terminal_connect});
      op(pot_regs_pkg::CMD_INC, 4'h1, 9'h0);
      chk("inc_we", 9'h2, wiper_cmd.we);
      chk("inc_op", pot_regs_pkg::CMD_INC, wiper_cmd.op);
      op(pot_regs_pkg::CMD_DEC, 4'h0, 9'h0);
      chk("dec_we", 9'h0, wiper_cmd.we);
      complete_run();
   end
endmodule
bind volatile_status_terminal_regs pot_regs_monitor pot_regs_monitor_inst (.clk, .reset_n, .cmd,
   .cmd_done, .wp_pin_n, .nv_busy, .nv_cfg, .nv_cfg_done, .resp, .wiper_cmd, .nv_wr,
   .terminal_connect, .general_call_accept_en);
